// ==== rtl/apl_map.vh ====
/*
  constants for the parallel attenuator controller: code width, mode pin
  levels, strobe timing and power-up wait.
  assumes a 250 MHz core clock.
*/
`ifndef APL_MAP_VH
`define APL_MAP_VH
`define APL_CODE_W 7
`define APL_CODE_MAX 7'h7F
`define APL_CODE_ZERO 7'h00
`define APL_SEL_PARALLEL 1'b0
`define APL_CLK_PERIOD_PS 4000
`define APL_STROBE_HIGH_NS 20
`define APL_STROBE_HIGH_CYC 26'h0000005 // 20 ns at 4 ns per cycle
`define APL_SETUP_NS 20
`define APL_SETUP_CYC 26'h0000005 // 20 ns at 4 ns per cycle
`define APL_PWRUP_MS 200
`define APL_PWRUP_CYC 26'h2FAF080 // 200 ms at 4 ns per cycle
`define APL_CNT_W 26
`endif

// ==== rtl/apl_sync.v ====
/*
  three-stage synchroniser with agreement filter for a pin input.
  assumes the pin is asynchronous to core_clk_i.
*/
`timescale 1ns/10ps
`default_nettype none
module apl_sync (
  input wire core_clk_i,
  input wire rst_n_i,
  input wire pin_i,
  output reg level_o
);
  reg s1_r;
  reg s2_r;
  reg s3_r;
  // first stage feeds only the second; level changes once stages 2 and 3 agree
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      level_o <= 1'b0;
    end else begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_o <= s3_r;
      end
    end
  end
endmodule // apl_sync
`default_nettype wire

// ==== rtl/apl_ctrl.v ====
/*
  host controller driving a digital step attenuator over its parallel pins:
  mode select, seven-bit code and latch strobe.
  assumes supply_good_i comes from an external supply monitor pin.
*/
// Overview of operation
// (R1) the controller drives the interface-select pin low to choose the parallel interface.
// (R2) the code is a binary sum with the top bit worth 16 dB and the bottom bit 0.25 dB.
// (R3) in direct mode the controller holds the latch strobe high all the time.
// (R4) in direct mode the device follows the code pins at once without any strobe.
// (R5) in latched mode the controller keeps the strobe low while it changes the code.
// (R6) once the code has settled the controller raises the strobe to pass the code through.
// (R7) the controller then drops the strobe, and the device holds the code on that edge.
// (R8) the controller drives the control pins only after the device supply is present.
// (R9) in latched mode the controller pulses the strobe after power-up to load its code.
// (R10) with the strobe low at power-up the device starts at maximum attenuation.
// (R11) the device takes its power-up state about 200 ms after power is applied.
`timescale 1ns/10ps
`default_nettype none
`include "apl_map.vh"
module apl_ctrl #(
  parameter [`APL_CNT_W-1:0] PWRUP_CYC = `APL_PWRUP_CYC
) (
  input wire core_clk_i,
  input wire rst_n_i,
  input wire supply_good_i,
  input wire direct_mode_i,
  input wire [`APL_CODE_W-1:0] code_i,
  input wire load_i,
  output reg busy_o,
  output reg powered_o,
  output reg [`APL_CODE_W-1:0] applied_code_o,
  output reg intf_sel_o,
  output reg intf_sel_oe_o,
  output reg [`APL_CODE_W-1:0] atten_code_in_o,
  output reg atten_code_in_oe_o,
  output reg latch_strobe_o,
  output reg latch_strobe_oe_o
);
  localparam [2:0] ST_OFF = 3'h0;
  localparam [2:0] ST_WAIT = 3'h1;
  localparam [2:0] ST_IDLE = 3'h2;
  localparam [2:0] ST_SETUP = 3'h3;
  localparam [2:0] ST_HIGH = 3'h4;
  localparam [2:0] ST_DIRECT = 3'h5;
  localparam [`APL_CNT_W-1:0] SETUP_CYC = `APL_SETUP_CYC;
  localparam [`APL_CNT_W-1:0] HIGH_CYC = `APL_STROBE_HIGH_CYC;
  localparam [`APL_CNT_W-1:0] CNT_ONE = 26'h0000001;

  wire supply_ok;
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [`APL_CNT_W-1:0] cnt_r;
  reg [`APL_CNT_W-1:0] cnt_nxt;
  reg [`APL_CODE_W-1:0] pend_r;
  reg [`APL_CODE_W-1:0] pend_nxt;
  reg pend_v_r;
  reg pend_v_nxt;

  apl_sync u_supply_sync (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .pin_i(supply_good_i),
    .level_o(supply_ok)
  );

  // next-state logic for power-up, strobe pulse and direct tracking
  always @* begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    pend_nxt = pend_r;
    pend_v_nxt = pend_v_r;
    if (load_i) begin
      pend_nxt = code_i; // binary-weighted code, msb 16 dB, lsb 0.25 dB (R2)
      pend_v_nxt = 1'b1;
    end
    case (state_r)
      ST_OFF: begin
        if (supply_ok) begin
          state_nxt = ST_WAIT; // pins driven only once supply is seen (R8)
          cnt_nxt = PWRUP_CYC;
        end
      end
      ST_WAIT: begin
        // let the device settle its own power-up state first (R11)
        if (cnt_r <= CNT_ONE) begin
          state_nxt = ST_IDLE;
          pend_v_nxt = 1'b1; // force one strobe pulse after power-up (R9)
        end else begin
          cnt_nxt = cnt_r - CNT_ONE;
        end
      end
      ST_IDLE: begin
        if (direct_mode_i) begin
          state_nxt = ST_DIRECT;
        end else if (pend_v_r) begin
          state_nxt = ST_SETUP; // strobe stays low while code changes (R5)
          cnt_nxt = SETUP_CYC;
          pend_v_nxt = load_i;
        end
      end
      ST_SETUP: begin
        if (cnt_r <= CNT_ONE) begin
          state_nxt = ST_HIGH; // settled, raise strobe (R6)
          cnt_nxt = HIGH_CYC;
        end else begin
          cnt_nxt = cnt_r - CNT_ONE;
        end
      end
      ST_HIGH: begin
        if (cnt_r <= CNT_ONE) begin
          state_nxt = ST_IDLE; // falling edge captures the code (R7)
        end else begin
          cnt_nxt = cnt_r - CNT_ONE;
        end
      end
      ST_DIRECT: begin
        if (!direct_mode_i) begin
          state_nxt = ST_IDLE;
          pend_v_nxt = 1'b1; // re-latch current code on leaving direct mode
        end
      end
      default: begin
        state_nxt = ST_OFF;
      end
    endcase
    if (!supply_ok) begin
      state_nxt = ST_OFF;
    end
  end

  // decoded next-state conditions shared by the output registers
  wire go_off;
  wire go_direct;
  wire go_setup;
  wire go_high;
  wire idle_quiet;
  assign go_off = (state_nxt == ST_OFF);
  assign go_direct = (state_nxt == ST_DIRECT);
  assign go_setup = (state_nxt == ST_SETUP) && (state_r != ST_SETUP);
  assign go_high = (state_nxt == ST_HIGH);
  // idle with no code pending and no mode change waiting
  assign idle_quiet = (state_nxt == ST_IDLE) && !pend_v_nxt && !direct_mode_i;

  // state, counter and pending code registers
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= ST_OFF;
      cnt_r <= {`APL_CNT_W{1'b0}};
      pend_r <= `APL_CODE_MAX;
      pend_v_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      pend_r <= pend_nxt;
      pend_v_r <= pend_v_nxt;
    end
  end

  // status flags; busy stays high across queued pulses and on leaving direct mode, low in direct mode
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_o <= 1'b1;
      powered_o <= 1'b0;
    end else begin
      powered_o <= !go_off;
      busy_o <= !(idle_quiet || go_direct);
    end
  end

  // pin enables and mode pin; all control pins released while supply is absent (R8)
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      intf_sel_o <= `APL_SEL_PARALLEL;
      intf_sel_oe_o <= 1'b0;
      atten_code_in_oe_o <= 1'b0;
      latch_strobe_oe_o <= 1'b0;
    end else begin
      intf_sel_o <= `APL_SEL_PARALLEL; // parallel interface selected (R1)
      intf_sel_oe_o <= !go_off;
      atten_code_in_oe_o <= !go_off;
      latch_strobe_oe_o <= !go_off;
    end
  end

  // latch strobe: high in direct mode and for each pulse, low otherwise
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      latch_strobe_o <= 1'b0;
    end else if (go_direct) begin
      latch_strobe_o <= 1'b1; // strobe held high in direct mode (R3)
    end else if (go_high) begin
      latch_strobe_o <= 1'b1; // (R6)
    end else begin
      latch_strobe_o <= 1'b0; // falling edge captures the code, low while unpowered (R7)
    end
  end

  // code pins: cleared to zero when supply is lost, otherwise change only at setup entry or follow the code in direct mode
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      atten_code_in_o <= `APL_CODE_ZERO;
    end else if (go_off) begin
      atten_code_in_o <= `APL_CODE_ZERO;
    end else if (go_direct) begin
      atten_code_in_o <= pend_nxt; // device follows pins at once (R4)
    end else if (go_setup) begin
      atten_code_in_o <= pend_r; // code changes only with strobe low (R5)
    end
  end

  // applied code as the device is expected to hold it
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      applied_code_o <= `APL_CODE_MAX;
    end else if (go_off) begin
      applied_code_o <= `APL_CODE_MAX; // device powers up at maximum attenuation (R10)
    end else if (go_direct) begin
      applied_code_o <= pend_nxt;
    end else if (go_high) begin
      applied_code_o <= atten_code_in_o; // code passes through while strobe high (R6)
    end
  end
endmodule // apl_ctrl
`default_nettype wire

// ==== bench/apl_checker.sv ====
/* pin sequencing checks for apl_ctrl; bound to its ports below */
`timescale 1ns/10ps
`default_nettype none
module apl_checker #(parameter [25:0] PWRUP_CYC = 26'h14) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic supply_good_i,
  input wire logic direct_mode_i,
  input wire logic busy_o,
  input wire logic powered_o,
  input wire logic [6:0] applied_code_o,
  input wire logic intf_sel_o,
  input wire logic intf_sel_oe_o,
  input wire logic [6:0] atten_code_in_o,
  input wire logic atten_code_in_oe_o,
  input wire logic latch_strobe_o,
  input wire logic latch_strobe_oe_o
);
  localparam int WAIT_MAX = PWRUP_CYC + 16;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // mode pin, strobe shape and code timing
  sel_low_a: assert property (intf_sel_oe_o |-> !intf_sel_o) else $error("sel high");
  dir_high_a: assert property (direct_mode_i [*3] ##0 (!busy_o && latch_strobe_oe_o)
    |-> latch_strobe_o) else $error("direct strobe low");
  code_hold_a: assert property (!direct_mode_i && !$past(direct_mode_i)
    && $changed(atten_code_in_o) |-> !latch_strobe_o) else $error("code moved");
  setup_low_a: assert property ($changed(atten_code_in_o) && !latch_strobe_o
    |=> !latch_strobe_o [*4]) else $error("setup short");
  pass_code_a: assert property ($rose(latch_strobe_o)
    |-> applied_code_o == atten_code_in_o) else $error("applied code");
  pulse_w_a: assert property ($rose(latch_strobe_o) && !direct_mode_i
    |-> latch_strobe_o [*5] ##1 !latch_strobe_o) else $error("pulse width");
  pwr_first_a: assert property ($rose(atten_code_in_oe_o)
    |-> $past(supply_good_i, 2)) else $error("early drive");
  first_pulse_a: assert property ($rose(powered_o) && !direct_mode_i
    |-> ##[1:WAIT_MAX] latch_strobe_o) else $error("no first pulse");
endmodule // apl_checker
bind apl_ctrl apl_checker #(.PWRUP_CYC(PWRUP_CYC)) u_apl_checker (.core_clk_i(core_clk_i),
  .rst_n_i(rst_n_i), .supply_good_i(supply_good_i), .direct_mode_i(direct_mode_i),
  .busy_o(busy_o), .powered_o(powered_o), .applied_code_o(applied_code_o),
  .intf_sel_o(intf_sel_o), .intf_sel_oe_o(intf_sel_oe_o), .atten_code_in_o(atten_code_in_o),
  .atten_code_in_oe_o(atten_code_in_oe_o), .latch_strobe_o(latch_strobe_o),
  .latch_strobe_oe_o(latch_strobe_oe_o));
`default_nettype wire

// ==== bench/apl_dev_model.sv ====
/* attenuator latch model; lines assumed on pull-downs */
`timescale 1ns/10ps
`default_nettype none
module apl_dev_model #(parameter int PWR_NS = 40) (
  input wire logic pwr_i,
  input wire logic sel_i,
  input wire logic strobe_i,
  input wire logic [6:0] code_i,
  output logic [6:0] held_o
);
  logic up = 1'b0;
  // power-up: strobe low gives maximum state, inputs taken after a delay
  always @(posedge pwr_i) begin
    up = 1'b0;
    held_o = 7'h7F;
    #PWR_NS up = 1'b1;
  end
  // open while strobe high, frozen after its fall; held_o in quarter dB
  always @* if (up && strobe_i && !sel_i) held_o = code_i;
endmodule // apl_dev_model
`default_nettype wire

// ==== bench/apl_ctrl_tb_top.sv ====
/* testbench for apl_ctrl; needs apl_dev_model and apl_checker */
`timescale 1ns/10ps
`default_nettype none
module apl_ctrl_tb_top;
  logic core_clk_i = 0, rst_n_i = 0, supply_good_i = 0, direct_mode_i = 0, load_i = 0;
  logic [6:0] code_i = 7'h00, last = 7'h7F, held, applied_code_o, atten_code_in_o;
  logic busy_o, powered_o, intf_sel_o, intf_sel_oe_o;
  logic atten_code_in_oe_o, latch_strobe_o, latch_strobe_oe_o;
  logic [31:0] rs = 32'h01C7;
  logic [6:0] exp_q[$];
  logic [6:0] exp_v;
  int n_errors = 0, tests_run = 0;
  // clock, design and device
  initial forever #2 core_clk_i = ~core_clk_i;
  apl_ctrl #(.PWRUP_CYC(26'h14)) u_apl_ctrl (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .supply_good_i(supply_good_i), .direct_mode_i(direct_mode_i), .code_i(code_i),
    .load_i(load_i), .busy_o(busy_o), .powered_o(powered_o), .applied_code_o(applied_code_o),
    .intf_sel_o(intf_sel_o), .intf_sel_oe_o(intf_sel_oe_o), .atten_code_in_o(atten_code_in_o),
    .atten_code_in_oe_o(atten_code_in_oe_o), .latch_strobe_o(latch_strobe_o),
    .latch_strobe_oe_o(latch_strobe_oe_o));
  apl_dev_model u_apl_dev_model (.pwr_i(supply_good_i), .sel_i(intf_sel_oe_o & intf_sel_o),
    .strobe_i(latch_strobe_oe_o & latch_strobe_o),
    .code_i(atten_code_in_o & {7{atten_code_in_oe_o}}), .held_o(held));
  task cmp(input string nm, input logic [6:0] e, input logic [6:0] s);
    tests_run++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected %s exp %h seen %h", nm, e, s);
    end
  endtask
  // xorshift step for random codes
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // new random code, never the one sent before, noted then loaded
  task send();
    rs = xs(rs);
    last = (rs[6:0] === last) ? ~last : rs[6:0];
    exp_q.push_back(last);
    @(posedge core_clk_i);
    code_i <= last;
    load_i <= 1'b1;
    @(posedge core_clk_i);
    load_i <= 1'b0;
  endtask
  task idle();
    repeat (3) @(posedge core_clk_i);
    for (int k = 0; k < 60 && busy_o !== 1'b0; k++) @(posedge core_clk_i);
  endtask
  task wrap_up();
    $display("tests_run %0d n_errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // each change of the held code answers the oldest note
  always @(held) if (powered_o === 1'b1) begin
    exp_v = exp_q.size() ? exp_q.pop_front() : ~held;
    cmp("held", exp_v, held);
    #1 cmp("applied", exp_v, applied_code_o);
  end
  initial begin
    repeat (2) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    send();
    supply_good_i <= 1'b1;
    repeat (10) @(posedge core_clk_i);
    cmp("powerup held", 7'h7F, held);
    cmp("powerup applied", 7'h7F, applied_code_o);
    cmp("powered", 7'h01, 7'(powered_o));
    repeat (30) @(posedge core_clk_i);
    idle();
    // odd loads arrive while a pulse runs
    for (int i = 0; i < 8; i++) begin
      send();
      if (i[0]) idle();
      else repeat (3) @(posedge core_clk_i);
    end
    direct_mode_i <= 1'b1;
    idle();
    repeat (5) send();
    direct_mode_i <= 1'b0;
    idle();
    send();
    idle();
    cmp("pending", 7'h00, 7'(exp_q.size()));
    wrap_up();
  end
  initial begin
    #20000;
    n_errors++;
    wrap_up();
  end
endmodule // apl_ctrl_tb_top
`default_nettype wire
